//--- rtl/sct_pkg.sv
// Constants shared by the six channel timer core
package sct_pkg;
	// ************************************************************
	// Register indices (byte address is four times the index)
	// ************************************************************
	localparam logic [11:0] TSC_IDX    = 12'h020;
	localparam logic [11:0] CNTH_IDX   = 12'h021;
	localparam logic [11:0] CNTL_IDX   = 12'h022;
	localparam logic [11:0] MODH_IDX   = 12'h023;
	localparam logic [11:0] MODL_IDX   = 12'h024;
	localparam logic [11:0] CH0_SC_IDX = 12'h030;
	localparam logic [11:0] CH1_SC_IDX = 12'h033;
	localparam logic [11:0] CH2_SC_IDX = 12'h456;
	localparam logic [11:0] CH3_SC_IDX = 12'h459;
	localparam logic [11:0] CH4_SC_IDX = 12'h45c;
	localparam logic [11:0] CH5_SC_IDX = 12'h45f;
	localparam logic [11:0] CHV_BASE   = 12'h400;
	localparam int          NCH        = 6;
	// ************************************************************
	// Field positions and reset values
	// ************************************************************
	localparam int          TOF_BIT    = 7;
	localparam int          OVERFLOW_IRQ_ENABLE_BIT   = 6;
	localparam int          STOP_BIT   = 5;
	localparam int          TRST_BIT   = 4;
	localparam int          FLAG_BIT   = 7;
	localparam int          IE_BIT     = 6;
	localparam int          MSB_BIT    = 5;
	localparam int          MSA_BIT    = 4;
	localparam int          ELSB_BIT   = 3;
	localparam int          ELSA_BIT   = 2;
	localparam int          TOV_BIT    = 1;
	localparam int          MAX_BIT    = 0;
	localparam logic [2:0]  PS_EXT     = 3'h7;
	localparam logic [2:0]  PS_RST     = 3'h0;
	localparam logic        STOP_RST   = 1'b1;
	localparam logic [15:0] MOD_RST    = 16'hffff;
	localparam logic [7:0]  SC_RST     = 8'h00;
	localparam logic [1:0]  ELS_TOG    = 2'h1;
	localparam logic [1:0]  ELS_CLR    = 2'h2;
	localparam logic [1:0]  ELS_SET    = 2'h3;
	localparam logic [1:0]  ELS_OFF    = 2'h0;
endpackage

//--- rtl/sct_chan.sv
// One capture/compare channel with its status and control register
`timescale 1ns/100ps
module sct_chan #(
	parameter bit HAS_BUF = 1'b0
) (
	input  wire logic        clk_sys,
	input  wire logic        rst_b,
	input  wire logic        sc_wr,
	input  wire logic        sc_rd,
	input  wire logic [7:0]  wdata,
	input  wire logic        brk_lock,
	input  wire logic        halt,
	input  wire logic        disable_i,
	input  wire logic        tick,
	input  wire logic        ovf,
	input  wire logic [15:0] count,
	input  wire logic [15:0] val_own,
	input  wire logic [15:0] val_alt,
	input  wire logic        own_wr,
	input  wire logic        alt_wr,
	input  wire logic        pin_in,
	output logic      [7:0]  sc_rdata,
	output logic             cap,
	output logic             buf_mode,
	output logic             irq_q,
	output logic             pin_out_q,
	output logic             pin_oe_b_q,
	output logic             timer_owns_q
);
	import sct_pkg::*;

	logic [6:0]  ctl_q;
	logic        flag_q;
	logic        arm_q;
	logic        pin_prev_q;
	logic        last_alt_q;
	logic        sel_alt_q;
	logic [1:0]  els;
	logic        active;
	logic        cap_mode;
	logic        cmp_mode;
	logic        match;
	logic        evt;
	logic [15:0] cmp_val;

	assign els      = ctl_q[ELSB_BIT:ELSA_BIT];
	assign buf_mode = HAS_BUF && ctl_q[MSB_BIT];
	assign active   = !disable_i && (els != ELS_OFF);
	assign cap_mode = active && !buf_mode && !ctl_q[MSA_BIT];
	assign cmp_mode = active && (buf_mode || ctl_q[MSA_BIT]);
	assign cmp_val  = (buf_mode && sel_alt_q) ? val_alt : val_own;
	assign match    = cmp_mode && tick && (count == cmp_val);
	assign cap      = cap_mode && !halt &&
		((els[0] && pin_in && !pin_prev_q) || (els[1] && !pin_in && pin_prev_q));
	assign evt      = match || cap;
	assign sc_rdata = {flag_q, ctl_q};

	// ************************************************************
	// Control bits
	// ************************************************************
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			ctl_q <= SC_RST[6:0];
		end else if (sc_wr && !disable_i) begin
			ctl_q <= wdata[6:0];
			if (!HAS_BUF) begin
				ctl_q[MSB_BIT] <= 1'b0;
			end
		end
	end

	// ************************************************************
	// Event flag with two-step clear
	// ************************************************************
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			flag_q <= 1'b0;
			arm_q  <= 1'b0;
		end else if (evt) begin
			flag_q <= 1'b1;
			arm_q  <= 1'b0;
		end else if (!brk_lock) begin
			if (sc_rd && flag_q) begin
				arm_q <= 1'b1;
			end
			if (sc_wr && !wdata[FLAG_BIT] && arm_q) begin
				flag_q <= 1'b0;
				arm_q  <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= flag_q && ctl_q[IE_BIT];
		end
	end

	// ************************************************************
	// Buffered value selection, switched at overflow
	// ************************************************************
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			last_alt_q <= 1'b0;
			sel_alt_q  <= 1'b0;
		end else begin
			if (alt_wr) begin
				last_alt_q <= 1'b1;
			end else if (own_wr) begin
				last_alt_q <= 1'b0;
			end
			if (!buf_mode) begin
				sel_alt_q <= 1'b0;
			end else if (ovf) begin
				sel_alt_q <= last_alt_q;
			end
		end
	end

	// ************************************************************
	// Pin drive
	// ************************************************************
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			pin_prev_q   <= 1'b0;
			pin_out_q    <= 1'b1;
			pin_oe_b_q   <= 1'b1;
			timer_owns_q <= 1'b0;
		end else begin
			pin_prev_q   <= pin_in;
			pin_oe_b_q   <= !cmp_mode;
			timer_owns_q <= active;
			if (els == ELS_OFF) begin
				pin_out_q <= !ctl_q[MSA_BIT];
			end else if (cmp_mode) begin
				if (ovf && ctl_q[TOV_BIT]) begin
					if (ctl_q[MAX_BIT]) begin
						pin_out_q <= (els == ELS_CLR);
					end else begin
						pin_out_q <= !pin_out_q;
					end
				end else if (match && !(ctl_q[MAX_BIT] && ctl_q[TOV_BIT])) begin
					unique case (els)
						ELS_TOG: pin_out_q <= !pin_out_q;
						ELS_CLR: pin_out_q <= 1'b0;
						ELS_SET: pin_out_q <= 1'b1;
						default: pin_out_q <= pin_out_q;
					endcase
				end
			end
		end
	end

	// ************************************************************
	// Checks
	// ************************************************************
	a_cap_when_halt: assert property (@(posedge clk_sys) disable iff (!rst_b)
		halt |-> !cap)
		else $error("capture taken while counter halted");
	a_flag_after_event: assert property (@(posedge clk_sys) disable iff (!rst_b)
		evt |=> flag_q && !arm_q)
		else $error("channel event did not set flag");
	a_nobuf_bit_zero: assert property (@(posedge clk_sys) disable iff (!rst_b)
		!HAS_BUF |-> !sc_rdata[MSB_BIT])
		else $error("missing buffer bit reads one");
endmodule

//--- rtl/sct_timer.sv
// Six channel timer core: counter, prescaler, modulo, APB registers
//
// Chosen here: register access over APB.
`timescale 1ns/100ps
// Overview of operation
// - Debug break halts counter and blocks all input captures.
// - Break with clear enable lets software clear flags; they stay cleared.
// - Break without clear enable: accesses keep flags; armed clear completes later.
// - Prescale code 111 counts on the channel 0 pin clock.
// - Channel 0 pin is input while it is the timer clock.
// - Six channels each capture or compare; 0, 2, 4 also buffered.
// - Overflow flag sets at modulo; read-then-write-0 clears; overflow blocks clear.
// - Overflow request only when enable set and flag set.
// - Stop bit freezes counter; reset leaves it set.
// - Stop bit inhibits input captures.
// - Counter reset bit clears counter and prescaler, self-clears, reads 0.
// - Stop and counter reset together leave counter halted at zero.
// - Prescale codes 000..110 divide bus clock by 1 to 64.
// - High byte read latches low byte until low byte is read.
// - Counter bytes read-only, cleared by reset and counter reset.
// - At modulo the flag sets and count restarts from zero.
// - Modulo high write suppresses overflow flag until low write.
// - Reset sets the modulo registers to all ones.
// - Channel control selects buffering, toggle, duty force and capture edge.
// - Channel flag sets on event; two-step clear; event blocks clear.
// - Buffered even channel disables the odd channel and frees its pin.
// - Edge bits 00 release the pin; mode bit A picks preset level.
module sct_timer (
	input  wire logic              clk_sys,
	input  wire logic              rst_b,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [15:0]       paddr,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	input  wire logic              break_active,
	input  wire logic              break_clear_enable,
	input  wire logic [sct_pkg::NCH-1:0] chan_pin_in,
	output logic      [sct_pkg::NCH-1:0] chan_pin_out,
	output logic      [sct_pkg::NCH-1:0] chan_pin_oe_b,
	output logic      [sct_pkg::NCH-1:0] chan_timer_owns,
	output logic                   overflow_irq,
	output logic      [sct_pkg::NCH-1:0] chan_irq
);
	import sct_pkg::*;

	localparam logic [11:0] SC_IDX [NCH] = '{CH0_SC_IDX, CH1_SC_IDX, CH2_SC_IDX,
		CH3_SC_IDX, CH4_SC_IDX, CH5_SC_IDX};

	logic [31:0] prdata_q;
	logic        pready_q;
	logic        pslverr_q;
	logic        tof_q;
	logic        tof_arm_q;
	logic        overflow_irq_enable_q;
	logic        stop_q;
	logic [2:0]  ps_q;
	logic [6:0]  pre_q;
	logic [15:0] count_q;
	logic [15:0] mod_q;
	logic        mod_inh_q;
	logic [7:0]  lat_lo_q;
	logic        lat_q;
	logic        irq_q;
	logic [2:0]  ext_s_q;
	logic        ext_pin_q;
	logic [15:0] val_q [NCH];
	logic [11:0] idx;
	logic        acc;
	logic        wr;
	logic        rd;
	logic [7:0]  wd;
	logic [7:0]  rdata;
	logic        mapped;
	logic        halt;
	logic        brk_lock;
	logic        tick;
	logic        ovf;
	logic        trst_wr;
	logic [6:0]  pmask;
	logic [NCH-1:0] sc_wr;
	logic [NCH-1:0] sc_rd;
	logic [NCH-1:0] vh_wr;
	logic [NCH-1:0] vl_wr;
	logic [NCH-1:0] cap;
	logic [NCH-1:0] bufm;
	logic [NCH-1:0] pin_out;
	logic [NCH-1:0] pin_oe_b;
	logic [NCH-1:0] owns;
	logic [7:0]  sc_rdata [NCH];

	// ************************************************************
	// APB slave, no wait states
	// ************************************************************
	assign idx     = paddr[13:2];
	assign acc     = psel && penable && pready_q;
	assign wr      = acc && pwrite;
	assign rd      = acc && !pwrite;
	assign wd      = pwdata[7:0];
	assign prdata  = prdata_q;
	assign pready  = pready_q;
	assign pslverr = pslverr_q;

	always_comb begin
		rdata  = 8'h00;
		mapped = (paddr[1:0] == 2'h0) && (paddr[15:14] == 2'h0);
		unique case (idx)
			TSC_IDX:  rdata = {tof_q, overflow_irq_enable_q, stop_q, 2'h0, ps_q};
			CNTH_IDX: rdata = count_q[15:8];
			CNTL_IDX: rdata = lat_q ? lat_lo_q : count_q[7:0];
			MODH_IDX: rdata = mod_q[15:8];
			MODL_IDX: rdata = mod_q[7:0];
			default:  rdata = 8'h00;
		endcase
		if (idx[11:4] == CHV_BASE[11:4] && idx[3:0] < 4'(2 * NCH)) begin
			rdata = idx[0] ? val_q[idx[3:1]][7:0] : val_q[idx[3:1]][15:8];
		end else if (!(idx inside {TSC_IDX, CNTH_IDX, CNTL_IDX, MODH_IDX, MODL_IDX})) begin
			mapped = mapped && (idx inside {SC_IDX});
		end
		for (int i = 0; i < NCH; i++) begin
			if (idx == SC_IDX[i]) begin
				rdata = sc_rdata[i];
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			prdata_q  <= 32'h0;
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
		end else if (psel && !penable) begin
			prdata_q  <= {24'h0, rdata};
			pready_q  <= 1'b1;
			pslverr_q <= !mapped;
		end else begin
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
		end
	end

	// ************************************************************
	// Status and control register
	// ************************************************************
	// break halts
	assign halt     = stop_q || break_active;
	assign brk_lock = break_active && !break_clear_enable;
	assign trst_wr  = wr && (idx == TSC_IDX) && wd[TRST_BIT];

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			overflow_irq_enable_q <= 1'b0;
			stop_q <= STOP_RST;
			ps_q   <= PS_RST;
		end else if (wr && idx == TSC_IDX) begin
			overflow_irq_enable_q <= wd[OVERFLOW_IRQ_ENABLE_BIT];
			stop_q <= wd[STOP_BIT];
			ps_q   <= wd[2:0];
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			tof_q     <= 1'b0;
			tof_arm_q <= 1'b0;
		end else if (ovf && !mod_inh_q) begin
			tof_q     <= 1'b1;
			tof_arm_q <= 1'b0;
		end else if (!brk_lock) begin
			if (rd && idx == TSC_IDX && tof_q) begin
				tof_arm_q <= 1'b1;
			end
			if (wr && idx == TSC_IDX && !wd[TOF_BIT] && tof_arm_q) begin
				tof_q     <= 1'b0;
				tof_arm_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= tof_q && overflow_irq_enable_q;
		end
	end
	assign overflow_irq = irq_q;

	// ************************************************************
	// Prescaler and clock source
	// ************************************************************
	// divide by two to the code
	assign pmask = 7'((8'h1 << ps_q) - 8'h1);
	assign tick  = !halt && ((ps_q == PS_EXT) ? (ext_s_q[1] && !ext_s_q[2])
		: ((pre_q & pmask) == pmask));

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			ext_s_q <= 3'h0;
		end else begin
			ext_s_q <= {ext_s_q[1:0], chan_pin_in[0]};
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			pre_q <= 7'h0;
		end else if (trst_wr) begin
			pre_q <= 7'h0;
		end else if (!halt) begin
			pre_q <= pre_q + 7'h1;
		end
	end

	// ************************************************************
	// Counter, modulo and read latch
	// ************************************************************
	assign ovf = tick && (count_q == mod_q);

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			count_q <= 16'h0;
		end else if (trst_wr) begin
			count_q <= 16'h0;
		end else if (tick) begin
			count_q <= (count_q == mod_q) ? 16'h0 : count_q + 16'h1;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			mod_q     <= MOD_RST;
			mod_inh_q <= 1'b0;
		end else if (wr && idx == MODH_IDX) begin
			mod_q[15:8] <= wd;
			mod_inh_q   <= 1'b1;
		end else if (wr && idx == MODL_IDX) begin
			mod_q[7:0] <= wd;
			mod_inh_q  <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			lat_lo_q <= 8'h0;
			lat_q    <= 1'b0;
		end else if (trst_wr) begin
			lat_lo_q <= 8'h0;
			lat_q    <= 1'b0;
		end else if (rd && idx == CNTH_IDX && !lat_q) begin
			lat_lo_q <= count_q[7:0];
			lat_q    <= 1'b1;
		end else if (rd && idx == CNTL_IDX) begin
			lat_q <= 1'b0;
		end
	end

	// ************************************************************
	// Channels
	// ************************************************************
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			for (int i = 0; i < NCH; i++) begin
				val_q[i] <= 16'h0;
			end
		end else begin
			for (int i = 0; i < NCH; i++) begin
				if (cap[i]) begin
					val_q[i] <= count_q;
				end else if (vh_wr[i]) begin
					val_q[i][15:8] <= wd;
				end else if (vl_wr[i]) begin
					val_q[i][7:0] <= wd;
				end
			end
		end
	end

	generate
		for (genvar c = 0; c < NCH; c++) begin : g_ch
			localparam bit EVEN = (c % 2) == 0;
			localparam int PART = EVEN ? c + 1 : c - 1;
			assign sc_wr[c] = wr && (idx == SC_IDX[c]);
			assign sc_rd[c] = rd && (idx == SC_IDX[c]);
			assign vh_wr[c] = wr && (idx == CHV_BASE + 12'(2 * c));
			assign vl_wr[c] = wr && (idx == CHV_BASE + 12'(2 * c + 1));
			sct_chan #(
				.HAS_BUF (EVEN)
			) u_chan (
				.clk_sys      (clk_sys),
				.rst_b        (rst_b),
				.sc_wr        (sc_wr[c]),
				.sc_rd        (sc_rd[c]),
				.wdata        (wd),
				.brk_lock     (brk_lock),
				.halt         (halt),
				.disable_i    (!EVEN && bufm[PART]),
				.tick         (tick),
				.ovf          (ovf),
				.count        (count_q),
				.val_own      (val_q[c]),
				.val_alt      (val_q[PART]),
				.own_wr       (vl_wr[c]),
				.alt_wr       (vl_wr[PART]),
				.pin_in       (chan_pin_in[c]),
				.sc_rdata     (sc_rdata[c]),
				.cap          (cap[c]),
				.buf_mode     (bufm[c]),
				.irq_q        (chan_irq[c]),
				.pin_out_q    (pin_out[c]),
				.pin_oe_b_q   (pin_oe_b[c]),
				.timer_owns_q (owns[c])
			);
		end
	endgenerate

	assign chan_pin_out         = pin_out;
	assign chan_pin_oe_b[0]     = pin_oe_b[0] || ext_pin_q;
	assign chan_pin_oe_b[NCH-1:1] = pin_oe_b[NCH-1:1];
	assign chan_timer_owns[0]   = owns[0] || ext_pin_q;
	assign chan_timer_owns[NCH-1:1] = owns[NCH-1:1];

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			ext_pin_q <= 1'b0;
		end else begin
			ext_pin_q <= (ps_q == PS_EXT);
		end
	end

	// ************************************************************
	// Checks
	// ************************************************************
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_b);

	sequence s_stop_rst_wr;
		wr && idx == TSC_IDX && wd[TRST_BIT] && wd[STOP_BIT];
	endsequence
	sequence s_held_zero;
		count_q == 16'h0 ##1 count_q == 16'h0;
	endsequence

	a_halt_freeze: assert property (halt && !trst_wr |=> $stable(count_q))
		else $error("counter moved while halted");
	a_trst_clear: assert property (trst_wr |=> count_q == 16'h0 && !lat_q)
		else $error("counter reset did not clear");
	a_stop_trst_zero: assert property (s_stop_rst_wr |=> s_held_zero)
		else $error("counter not held at zero");
	a_modulo_wrap: assert property (ovf && !trst_wr |=> count_q == 16'h0)
		else $error("counter did not wrap at modulo");
	a_tof_set: assert property (ovf && !mod_inh_q |=> tof_q)
		else $error("overflow flag not set");
	a_mod_inhibit: assert property (mod_inh_q && !tof_q |=> !tof_q)
		else $error("flag set during modulo update");
	a_irq_gate: assert property (overflow_irq |-> $past(tof_q && overflow_irq_enable_q))
		else $error("overflow request without flag and enable");
	a_break_keep: assert property (brk_lock && tof_q |=> tof_q)
		else $error("flag cleared under break lock");
endmodule

//--- dv/sct_pin_model.sv
// Far-side model of the timer channel pins and external clock
`timescale 1ns/100ps
module sct_pin_model (
	input  wire logic       clk_sys,
	output logic      [5:0] pin
);
	initial pin = 6'h00;
	// Slow external clock
	// Eight bus clocks high and low keeps the rate under both limits
	task automatic ext_pulses(input int n);
		repeat (n) begin
			@(posedge clk_sys) pin[0] <= 1'b1;
			repeat (8) @(posedge clk_sys);
			pin[0] <= 1'b0;
			repeat (7) @(posedge clk_sys);
		end
	endtask
	task automatic pin_pulse(input int ch);
		@(posedge clk_sys) pin[ch] <= 1'b1;
		repeat (6) @(posedge clk_sys);
		pin[ch] <= 1'b0;
		repeat (6) @(posedge clk_sys);
	endtask
endmodule

//--- dv/tb_top.sv
// Self-checking bench for the six channel timer core
`timescale 1ns/100ps
module tb_top;
	import sct_pkg::*;
	logic        clk_sys = 1'b0;
	logic        rst_b = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [15:0] paddr = 16'h0000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        brk = 1'b0;
	logic        bce = 1'b0;
	logic [5:0]  pin;
	logic [5:0]  pout;
	logic [5:0]  oe_b;
	logic [5:0]  owns;
	logic [5:0]  cirq;
	logic        oirq;
	int          n_fail = 0;
	int          checks_done = 0;
	int          cyc = 0;
	sct_timer DUT (
		.clk_sys           (clk_sys),
		.rst_b             (rst_b),
		.psel              (psel),
		.penable           (penable),
		.pwrite            (pwrite),
		.paddr             (paddr),
		.pwdata            (pwdata),
		.prdata            (prdata),
		.pready            (pready),
		.pslverr           (pslverr),
		.break_active      (brk),
		.break_clear_enable(bce),
		.chan_pin_in       (pin),
		.chan_pin_out      (pout),
		.chan_pin_oe_b     (oe_b),
		.chan_timer_owns   (owns),
		.overflow_irq      (oirq),
		.chan_irq          (cirq)
	);
	sct_pin_model pins (
		.clk_sys(clk_sys),
		.pin    (pin)
	);
	// ************************************************************
	// Clock, timeout and shared tasks
	// ************************************************************
	always #20 clk_sys = ~clk_sys;
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 20000) begin
			n_fail++;
			summarize();
		end
	end
	task automatic summarize();
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_fail++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic apb(input logic wr, input logic [11:0] idx, input logic [7:0] wd,
		output logic [7:0] rd, output logic err);
		int n;
		n = 0;
		@(posedge clk_sys);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= {2'h0, idx, 2'h0};
		pwdata  <= {24'h0, wd};
		@(posedge clk_sys);
		penable <= 1'b1;
		do begin
			@(posedge clk_sys);
			n++;
		end while (pready !== 1'b1 && n < 50);
		rd = prdata[7:0];
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [11:0] idx, input logic [7:0] wd);
		logic [7:0] d;
		logic       e;
		apb(1'b1, idx, wd, d, e);
	endtask
	task automatic rdc(input string what, input logic [11:0] idx, input logic [7:0] exp);
		logic [7:0] d;
		logic       e;
		apb(1'b0, idx, 8'h00, d, e);
		chk(what, {23'h0, e, d}, {24'h0, exp});
	endtask
	// ************************************************************
	// Scenarios
	// ************************************************************
	task automatic t_reset();
		logic [7:0] d;
		logic       e;
		chk("reset pins", {26'h0, pout}, 32'h3f);
		chk("reset owns", {26'h0, owns}, 32'h0);
		chk("reset chan irq", {26'h0, cirq}, 32'h0);
		rdc("status", TSC_IDX, 8'h20);
		rdc("modulo high", MODH_IDX, 8'hff);
		rdc("modulo low", MODL_IDX, 8'hff);
		repeat (20) @(posedge clk_sys);
		wr(CNTL_IDX, 8'h55);
		rdc("halted count", CNTL_IDX, 8'h00);
		rdc("ch2 control", CH2_SC_IDX, SC_RST);
		wr(CH1_SC_IDX, 8'h20);
		rdc("ch1 buffer bit", CH1_SC_IDX, 8'h00);
		wr(CH3_SC_IDX, 8'h10);
		repeat (2) @(posedge clk_sys);
		chk("ch3 preset low", {31'h0, pout[3]}, 32'h0);
		wr(CH2_SC_IDX, 8'h20);
		wr(CH3_SC_IDX, 8'h14);
		rdc("ch3 disabled", CH3_SC_IDX, 8'h10);
		wr(CH2_SC_IDX, 8'h00);
		wr(CH3_SC_IDX, 8'h00);
		repeat (2) @(posedge clk_sys);
		chk("ch3 preset high", {31'h0, pout[3]}, 32'h1);
		apb(1'b0, 12'h100, 8'h00, d, e);
		chk("unmapped", {23'h0, e, d}, 32'h100);
		$display("test reset done");
	endtask
	task automatic t_ovf();
		wr(MODH_IDX, 8'h00);
		wr(MODL_IDX, 8'h04);
		wr(TSC_IDX, 8'h40);
		repeat (20) @(posedge clk_sys);
		chk("overflow irq", {31'h0, oirq}, 32'h1);
		rdc("status ovf", TSC_IDX, 8'hc0);
		repeat (10) @(posedge clk_sys);
		wr(TSC_IDX, 8'h60);
		rdc("clear blocked", TSC_IDX, 8'he0);
		wr(TSC_IDX, 8'he0);
		rdc("write one", TSC_IDX, 8'he0);
		wr(TSC_IDX, 8'h60);
		rdc("flag cleared", TSC_IDX, 8'h60);
		chk("irq dropped", {31'h0, oirq}, 32'h0);
		wr(TSC_IDX, 8'h70);
		rdc("count high", CNTH_IDX, 8'h00);
		rdc("count low", CNTL_IDX, 8'h00);
		rdc("reset bit", TSC_IDX, 8'h60);
		$display("test overflow done");
	endtask
	// Stop lands half a prescaled period after the fourth tick
	task automatic t_pre();
		wr(MODH_IDX, 8'hff);
		wr(MODL_IDX, 8'hff);
		for (int ps = 1; ps < 7; ps++) begin
			wr(TSC_IDX, 8'h10 | 8'(ps));
			repeat ((1 << ps) * 4 + (1 << (ps - 1)) - 3) @(posedge clk_sys);
			wr(TSC_IDX, 8'h20 | 8'(ps));
			rdc("scaled count", CNTL_IDX, 8'h04);
		end
		$display("test prescaler done");
	endtask
	task automatic t_ext();
		wr(TSC_IDX, 8'h17);
		repeat (2) @(posedge clk_sys);
		chk("ch0 pin input", {31'h0, oe_b[0]}, 32'h1);
		chk("ch0 pin owned", {31'h0, owns[0]}, 32'h1);
		pins.ext_pulses(5);
		rdc("count high", CNTH_IDX, 8'h00);
		pins.ext_pulses(2);
		rdc("held low", CNTL_IDX, 8'h05);
		rdc("count high", CNTH_IDX, 8'h00);
		rdc("ext count", CNTL_IDX, 8'h07);
		@(posedge clk_sys) brk <= 1'b1;
		pins.ext_pulses(3);
		rdc("count high", CNTH_IDX, 8'h00);
		rdc("break count", CNTL_IDX, 8'h07);
		@(posedge clk_sys) brk <= 1'b0;
		$display("test external clock done");
	endtask
	task automatic t_cap();
		wr(CH2_SC_IDX, 8'h04);
		wr(TSC_IDX, 8'h27);
		pins.pin_pulse(2);
		rdc("ch2 stopped", CH2_SC_IDX, 8'h04);
		wr(TSC_IDX, 8'h07);
		@(posedge clk_sys) brk <= 1'b1;
		pins.pin_pulse(2);
		rdc("ch2 in break", CH2_SC_IDX, 8'h04);
		@(posedge clk_sys) brk <= 1'b0;
		pins.pin_pulse(2);
		rdc("ch2 flag", CH2_SC_IDX, 8'h84);
		@(posedge clk_sys) brk <= 1'b1;
		wr(CH2_SC_IDX, 8'h04);
		rdc("ch2 kept", CH2_SC_IDX, 8'h84);
		@(posedge clk_sys) brk <= 1'b0;
		wr(CH2_SC_IDX, 8'h04);
		rdc("ch2 cleared", CH2_SC_IDX, 8'h04);
		pins.pin_pulse(2);
		@(posedge clk_sys) brk <= 1'b1;
		bce <= 1'b1;
		rdc("ch2 armed", CH2_SC_IDX, 8'h84);
		wr(CH2_SC_IDX, 8'h04);
		@(posedge clk_sys) brk <= 1'b0;
		rdc("ch2 stays clear", CH2_SC_IDX, 8'h04);
		$display("test capture done");
	endtask
	initial begin
		repeat (16) @(posedge clk_sys);
		rst_b <= 1'b1;
		t_reset();
		t_ovf();
		t_pre();
		t_ext();
		t_cap();
		summarize();
	end
endmodule
